// >>> design/sensor_irq_pkg.sv
// Constants and carrier types for the sensor threshold interrupt block.
// Assumes one internal clock shared by the register port and the ADC side.
package sensor_irq_pkg;

	// Register offsets
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_CONFIG = 8'h01;
	localparam logic [7:0] ADDR_AMB_DATA_HI = 8'h04;
	localparam logic [7:0] ADDR_AMB_DATA_LO = 8'h05;
	localparam logic [7:0] ADDR_UP_HI = 8'h06;
	localparam logic [7:0] ADDR_UP_LO = 8'h07;
	localparam logic [7:0] ADDR_LO_HI = 8'h08;
	localparam logic [7:0] ADDR_LO_LO = 8'h09;
	localparam logic [7:0] ADDR_PERSIST = 8'h0a;
	localparam logic [7:0] ADDR_PROX_DIR = 8'h0b;
	localparam logic [7:0] ADDR_PROX_LIMIT = 8'h0c;
	localparam logic [7:0] ADDR_TRIM_GREEN = 8'h0f;
	localparam logic [7:0] ADDR_TRIM_IR = 8'h10;

	// Reset values
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_TRIM = 8'h80;

	// Field positions
	localparam int CFG_AMB_EN = 0;
	localparam int CFG_PROX_EN = 1;
	localparam int CFG_MODE_LO = 2;
	localparam int CFG_MODE_HI = 4;
	localparam int CFG_GAIN_SRC = 5;
	localparam int ST_AMB = 0;
	localparam int ST_PROX = 1;
	localparam int ST_PWR = 2;
	localparam int PERS_AMB_LO = 0;
	localparam int PERS_AMB_HI = 1;
	localparam int PERS_PROX_LO = 2;
	localparam int PERS_PROX_HI = 3;
	localparam int PROX_DIR_BIT = 6;
	localparam int LIMIT_HI_BITS = 6;

	// Ambient result source, from config mode field
	localparam logic [2:0] MODE_GREEN_ONLY = 3'h1;
	localparam logic [2:0] MODE_IR_ONLY = 3'h2;

	// Persist run lengths
	localparam logic [4:0] RUN_1 = 5'h01;
	localparam logic [4:0] RUN_2 = 5'h02;
	localparam logic [4:0] RUN_4 = 5'h04;
	localparam logic [4:0] RUN_16 = 5'h10;

	// Factory trims applied while the gain source bit is 1
	localparam logic [6:0] FACTORY_GREEN = 7'h40;
	localparam logic [8:0] FACTORY_IR = 9'h100;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] data;
	} reg_req_t;

	typedef struct packed {
		logic done;
		logic overrange;
		logic [13:0] green;
		logic [13:0] ir;
	} amb_sample_t;

	typedef struct packed {
		logic done;
		logic [7:0] value;
	} prox_sample_t;

	typedef struct packed {
		logic [6:0] green;
		logic [8:0] ir;
	} trim_t;

	typedef struct packed {
		logic [7:0] upHi;
		logic [7:0] upLo;
		logic [7:0] loHi;
		logic [7:0] loLo;
		logic [7:0] persist;
		logic [7:0] proxDir;
		logic [7:0] proxLimit;
		logic [7:0] trimGreen;
		logic [7:0] trimIr;
		logic [7:0] mainCfg;
		logic ambFlag;
		logic proxFlag;
		logic pwrFlag;
		logic [4:0] ambCnt;
		logic [4:0] proxCnt;
		logic [13:0] ambResult;
		logic ambOver;
		logic ambValid;
		logic [7:0] rdData;
		logic intOe;
		trim_t applied;
	} state_t;

endpackage

// >>> design/sensor_threshold_interrupt.sv
// Threshold, persist and status logic of a light and proximity sensor.
// Assumes a serial-bus front end that issues one-cycle register strobes
// and an ADC side that pulses done once per measurement, all on mclk.
`timescale 1ns/10ps

module sensor_threshold_interrupt
(
	input wire logic mclk,
	input wire logic reset,
	input wire sensor_irq_pkg::reg_req_t regReq,
	input wire sensor_irq_pkg::amb_sample_t ambSample,
	input wire sensor_irq_pkg::prox_sample_t proxSample,
	output logic [7:0] regRdData,
	output logic intOut,
	output logic intOe,
	output logic [13:0] ambResult,
	output logic ambResultValid,
	output sensor_irq_pkg::trim_t gainTrim
);

	sensor_irq_pkg::state_t s_r;
	sensor_irq_pkg::state_t s_nxt;

	function automatic logic [4:0] runLength(input logic [1:0] sel);
		logic [4:0] n;
		n = sensor_irq_pkg::RUN_1;
		case (sel)
			2'h0: n = sensor_irq_pkg::RUN_1;
			2'h1: n = sensor_irq_pkg::RUN_2;
			2'h2: n = sensor_irq_pkg::RUN_4;
			default: n = sensor_irq_pkg::RUN_16;
		endcase
		return n;
	endfunction

	// Next count of a run, saturating at the run length so it cannot wrap
	function automatic logic [4:0] runStep(input logic [4:0] cnt,
		input logic [4:0] need);
		logic [4:0] n;
		n = cnt;
		if (cnt < need)
		begin
			n = cnt + 5'h01;
		end
		return n;
	endfunction

	logic ambEn;
	logic proxEn;
	logic rdStatus;
	logic [13:0] upLimit;
	logic [13:0] loLimit;
	logic [13:0] ambValue;
	logic [2:0] mode;
	logic ambEvent;
	logic proxEvent;
	logic [4:0] ambNeed;
	logic [4:0] proxNeed;
	logic [4:0] ambRun;
	logic [4:0] proxRun;
	logic ambSet;
	logic proxSet;

	always_comb
	begin
		s_nxt = s_r;
		ambEn = s_r.mainCfg[sensor_irq_pkg::CFG_AMB_EN];
		proxEn = s_r.mainCfg[sensor_irq_pkg::CFG_PROX_EN];
		mode = s_r.mainCfg[sensor_irq_pkg::CFG_MODE_HI:
			sensor_irq_pkg::CFG_MODE_LO];
		rdStatus = regReq.rd && (regReq.addr == sensor_irq_pkg::ADDR_STATUS);
		upLimit = {s_r.upHi[sensor_irq_pkg::LIMIT_HI_BITS-1:0], s_r.upLo};
		loLimit = {s_r.loHi[sensor_irq_pkg::LIMIT_HI_BITS-1:0], s_r.loLo};

		// Ambient result; a negative difference floors at zero
		if (mode == sensor_irq_pkg::MODE_GREEN_ONLY)
		begin
			ambValue = ambSample.green;
		end
		else if (mode == sensor_irq_pkg::MODE_IR_ONLY)
		begin
			ambValue = ambSample.ir;
		end
		else if (ambSample.green > ambSample.ir)
		begin
			ambValue = ambSample.green - ambSample.ir;
		end
		else
		begin
			ambValue = '0;
		end

		// Event tests; limits compare raw counts
		ambEvent = ambEn && ((ambValue > upLimit) || (ambValue < loLimit)
			|| ambSample.overrange);
		if (s_r.proxDir[sensor_irq_pkg::PROX_DIR_BIT])
		begin
			proxEvent = proxEn && (proxSample.value > s_r.proxLimit);
		end
		else
		begin
			proxEvent = proxEn && (proxSample.value < s_r.proxLimit);
		end

		ambNeed = runLength(s_r.persist[sensor_irq_pkg::PERS_AMB_HI:
			sensor_irq_pkg::PERS_AMB_LO]);
		proxNeed = runLength(s_r.persist[sensor_irq_pkg::PERS_PROX_HI:
			sensor_irq_pkg::PERS_PROX_LO]);
		ambRun = runStep(s_r.ambCnt, ambNeed);
		proxRun = runStep(s_r.proxCnt, proxNeed);
		ambSet = 1'b0;
		proxSet = 1'b0;

		// Ambient channel counter steps only on its own measurements
		s_nxt.ambValid = ambSample.done;
		if (ambSample.done)
		begin
			s_nxt.ambResult = ambValue;
			s_nxt.ambOver = ambSample.overrange;
			if (ambEvent)
			begin
				s_nxt.ambCnt = ambRun;
				ambSet = (ambRun >= ambNeed);
			end
			else
			begin
				s_nxt.ambCnt = '0;
			end
		end
		if (!ambEn)
		begin
			s_nxt.ambCnt = '0;
		end

		// Proximity channel, filtered the same way
		if (proxSample.done)
		begin
			if (proxEvent)
			begin
				s_nxt.proxCnt = proxRun;
				proxSet = (proxRun >= proxNeed);
			end
			else
			begin
				s_nxt.proxCnt = '0;
			end
		end
		if (!proxEn)
		begin
			s_nxt.proxCnt = '0;
		end

		// A new event in the reading cycle survives the clear
		s_nxt.ambFlag = ambEn && (ambSet || (s_r.ambFlag && !rdStatus));
		s_nxt.proxFlag = proxEn
			&& (proxSet || (s_r.proxFlag && !rdStatus));
		s_nxt.pwrFlag = s_r.pwrFlag && !rdStatus;

		// Register writes
		if (regReq.wr)
		begin
			if (regReq.addr == sensor_irq_pkg::ADDR_CONFIG)
			begin
				s_nxt.mainCfg = regReq.data;
			end
			else if (regReq.addr == sensor_irq_pkg::ADDR_UP_HI)
			begin
				s_nxt.upHi = {2'h0,
					regReq.data[sensor_irq_pkg::LIMIT_HI_BITS-1:0]};
			end
			else if (regReq.addr == sensor_irq_pkg::ADDR_UP_LO)
			begin
				s_nxt.upLo = regReq.data;
			end
			else if (regReq.addr == sensor_irq_pkg::ADDR_LO_HI)
			begin
				s_nxt.loHi = {2'h0,
					regReq.data[sensor_irq_pkg::LIMIT_HI_BITS-1:0]};
			end
			else if (regReq.addr == sensor_irq_pkg::ADDR_LO_LO)
			begin
				s_nxt.loLo = regReq.data;
			end
			else if (regReq.addr == sensor_irq_pkg::ADDR_PERSIST)
			begin
				s_nxt.persist = {4'h0, regReq.data[3:0]};
			end
			else if (regReq.addr == sensor_irq_pkg::ADDR_PROX_DIR)
			begin
				s_nxt.proxDir = '0;
				s_nxt.proxDir[sensor_irq_pkg::PROX_DIR_BIT] =
					regReq.data[sensor_irq_pkg::PROX_DIR_BIT];
			end
			else if (regReq.addr == sensor_irq_pkg::ADDR_PROX_LIMIT)
			begin
				s_nxt.proxLimit = regReq.data;
			end
			else if (regReq.addr == sensor_irq_pkg::ADDR_TRIM_GREEN)
			begin
				s_nxt.trimGreen = regReq.data;
			end
			else if (regReq.addr == sensor_irq_pkg::ADDR_TRIM_IR)
			begin
				s_nxt.trimIr = regReq.data;
			end
		end

		// Read data, registered; status shows flags before the clear
		if (regReq.rd)
		begin
			if (regReq.addr == sensor_irq_pkg::ADDR_STATUS)
			begin
				s_nxt.rdData = '0;
				s_nxt.rdData[sensor_irq_pkg::ST_AMB] = s_r.ambFlag;
				s_nxt.rdData[sensor_irq_pkg::ST_PROX] = s_r.proxFlag;
				s_nxt.rdData[sensor_irq_pkg::ST_PWR] = s_r.pwrFlag;
			end
			else if (regReq.addr == sensor_irq_pkg::ADDR_CONFIG)
			begin
				s_nxt.rdData = s_r.mainCfg;
			end
			else if (regReq.addr == sensor_irq_pkg::ADDR_AMB_DATA_HI)
			begin
				s_nxt.rdData = {1'b0, s_r.ambOver, s_r.ambResult[13:8]};
			end
			else if (regReq.addr == sensor_irq_pkg::ADDR_AMB_DATA_LO)
			begin
				s_nxt.rdData = s_r.ambResult[7:0];
			end
			else if (regReq.addr == sensor_irq_pkg::ADDR_UP_HI)
			begin
				s_nxt.rdData = s_r.upHi;
			end
			else if (regReq.addr == sensor_irq_pkg::ADDR_UP_LO)
			begin
				s_nxt.rdData = s_r.upLo;
			end
			else if (regReq.addr == sensor_irq_pkg::ADDR_LO_HI)
			begin
				s_nxt.rdData = s_r.loHi;
			end
			else if (regReq.addr == sensor_irq_pkg::ADDR_LO_LO)
			begin
				s_nxt.rdData = s_r.loLo;
			end
			else if (regReq.addr == sensor_irq_pkg::ADDR_PERSIST)
			begin
				s_nxt.rdData = s_r.persist;
			end
			else if (regReq.addr == sensor_irq_pkg::ADDR_PROX_DIR)
			begin
				s_nxt.rdData = s_r.proxDir;
			end
			else if (regReq.addr == sensor_irq_pkg::ADDR_PROX_LIMIT)
			begin
				s_nxt.rdData = s_r.proxLimit;
			end
			else if (regReq.addr == sensor_irq_pkg::ADDR_TRIM_GREEN)
			begin
				s_nxt.rdData = ~s_r.trimGreen;
			end
			else if (regReq.addr == sensor_irq_pkg::ADDR_TRIM_IR)
			begin
				s_nxt.rdData = ~s_r.trimIr;
			end
			else
			begin
				s_nxt.rdData = '0;
			end
		end

		// Host trims only reach the channels while gain source is zero
		if (s_r.mainCfg[sensor_irq_pkg::CFG_GAIN_SRC])
		begin
			s_nxt.applied.green = sensor_irq_pkg::FACTORY_GREEN;
			s_nxt.applied.ir = sensor_irq_pkg::FACTORY_IR;
		end
		else
		begin
			s_nxt.applied.green = s_r.trimGreen[7:1];
			s_nxt.applied.ir = {s_r.trimIr, s_r.trimGreen[0]};
		end

		// Power-up flag alone does not pull the line
		s_nxt.intOe = s_nxt.ambFlag || s_nxt.proxFlag;
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			s_r <= '0;
			s_r.trimGreen <= sensor_irq_pkg::RST_TRIM;
			s_r.trimIr <= sensor_irq_pkg::RST_TRIM;
			s_r.applied.green <= sensor_irq_pkg::RST_TRIM[7:1];
			s_r.applied.ir <= {sensor_irq_pkg::RST_TRIM, 1'b0};
			s_r.pwrFlag <= 1'b1;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	assign regRdData = s_r.rdData;
	assign intOut = 1'b0; // Open drain: only ever drives low
	assign intOe = s_r.intOe;
	assign ambResult = s_r.ambResult;
	assign ambResultValid = s_r.ambValid;
	assign gainTrim = s_r.applied;

endmodule

// >>> test/sensor_irq_properties.sv
// Concurrent checks on the top ports of the threshold interrupt block.
// Assumes mclk and reset of the design; shadows host register writes.
`timescale 1ns/10ps
module sensor_irq_properties
(
	input wire logic mclk,
	input wire logic reset,
	input wire sensor_irq_pkg::reg_req_t regReq,
	input wire sensor_irq_pkg::amb_sample_t ambSample,
	input wire sensor_irq_pkg::prox_sample_t proxSample,
	input wire logic [7:0] regRdData,
	input wire logic intOut,
	input wire logic intOe,
	input wire logic [13:0] ambResult,
	input wire logic ambResultValid,
	input wire sensor_irq_pkg::trim_t gainTrim
);
	logic [7:0] cfg_r, pers_r, dir_r, lim_r, trimG_r;
	logic [13:0] diff;
	logic proxHit;
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	always_ff @(posedge mclk or posedge reset)
		if (reset)
		begin
			cfg_r <= 8'h00;
			pers_r <= 8'h00;
			dir_r <= 8'h00;
			lim_r <= 8'h00;
			trimG_r <= 8'h80;
		end
		else if (regReq.wr)
		begin
			case (regReq.addr)
				sensor_irq_pkg::ADDR_CONFIG: cfg_r <= regReq.data;
				sensor_irq_pkg::ADDR_PERSIST: pers_r <= regReq.data;
				sensor_irq_pkg::ADDR_PROX_DIR: dir_r <= regReq.data;
				sensor_irq_pkg::ADDR_PROX_LIMIT: lim_r <= regReq.data;
				sensor_irq_pkg::ADDR_TRIM_GREEN: trimG_r <= regReq.data;
				default: ;
			endcase
		end
	assign diff = (ambSample.green > ambSample.ir) ?
		ambSample.green - ambSample.ir : 14'h0000;
	assign proxHit = dir_r[6] ? proxSample.value > lim_r :
		proxSample.value < lim_r;
	chk_valid_pulse: assert property (ambSample.done |=> ambResultValid)
		else $error("result valid missing");
	chk_amb_diff: assert property (cfg_r[4:2] == 3'h0 && ambSample.done
		|=> ambResult == $past(diff)) else $error("ambient result wrong");
	chk_od_low: assert property (intOut == 1'b0)
		else $error("interrupt data not low");
	chk_off_clear: assert property (!cfg_r[0] && !cfg_r[1] |=> !intOe)
		else $error("interrupt while disabled");
	chk_rd_clear: assert property (regReq.rd && regReq.addr ==
		sensor_irq_pkg::ADDR_STATUS && !ambSample.done && !proxSample.done
		|=> !intOe) else $error("status read did not clear");
	chk_first_event: assert property (cfg_r[0] && pers_r[1:0] == 2'b00
		&& ambSample.done && ambSample.overrange |=> intOe)
		else $error("overrange did not interrupt");
	chk_prox_event: assert property (cfg_r[1] && pers_r[3:2] == 2'b00
		&& proxSample.done && proxHit |=> intOe)
		else $error("proximity event missed");
	chk_trim_read: assert property (regReq.rd && regReq.addr ==
		sensor_irq_pkg::ADDR_TRIM_GREEN |=> regRdData == ~$past(trimG_r))
		else $error("trim read not complemented");
	chk_trim_apply: assert property (regReq.wr && !cfg_r[5] && regReq.addr
		== sensor_irq_pkg::ADDR_TRIM_GREEN |-> ##2 gainTrim.green ==
		trimG_r[7:1]) else $error("host trim not applied");
	chk_factory_trim: assert property (cfg_r[5] [*3] |-> gainTrim ==
		{sensor_irq_pkg::FACTORY_GREEN, sensor_irq_pkg::FACTORY_IR})
		else $error("factory trim not applied");
	cover property (ambSample.done && ambSample.overrange ##1 intOe);
	cover property (proxSample.done ##1 intOe);
	cover property (regReq.rd && regReq.addr == 8'h00 && intOe);
endmodule

// >>> test/reg_host_model.sv
// Register host model: one-cycle strobes on the register port.
// Assumes the bench calls its task; drives on the falling edge.
`timescale 1ns/10ps
module reg_host_model
(
	input wire logic mclk,
	output sensor_irq_pkg::reg_req_t regReq
);
	initial regReq = '0;
	// Unqualified lines get inverted values so nothing stale looks valid
	task automatic access(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		@(negedge mclk);
		regReq = '{wr: w, rd: !w, addr: a, data: d};
		@(negedge mclk);
		regReq = '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
	endtask
endmodule

// >>> test/sensor_threshold_interrupt_bench.sv
// Self-checking bench for the threshold interrupt block.
// Assumes the package, the design, the host model and the checker.
`timescale 1ns/10ps
module sensor_threshold_interrupt_bench;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	sensor_irq_pkg::reg_req_t regReq;
	sensor_irq_pkg::amb_sample_t ambSample = '0;
	sensor_irq_pkg::prox_sample_t proxSample = '0;
	sensor_irq_pkg::trim_t gainTrim;
	logic [7:0] regRdData;
	logic intOut, intOe, ambResultValid, rdPend;
	logic [13:0] ambResult;
	logic [7:0] rdQ[$];
	logic [13:0] ambQ[$];
	logic [31:0] seed = 32'h42871de5;
	int n_fail = 0;
	int compares = 0;
	int cycles = 0;
	always #50 mclk = ~mclk;
	reg_host_model reg_host_model_inst (.mclk(mclk), .regReq(regReq));
	sensor_threshold_interrupt sensor_threshold_interrupt_inst (.mclk(mclk),
		.reset(reset), .regReq(regReq), .ambSample(ambSample),
		.proxSample(proxSample), .regRdData(regRdData), .intOut(intOut),
		.intOe(intOe), .ambResult(ambResult),
		.ambResultValid(ambResultValid), .gainTrim(gainTrim));
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic check(input logic ok, input string msg);
		compares++;
		if (ok !== 1'b1)
		begin
			n_fail++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask
	task automatic wrap_up();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_host_model_inst.access(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		rdQ.push_back(e);
		reg_host_model_inst.access(1'b0, a, 8'h00);
	endtask
	task automatic amb(input logic [13:0] g, input logic [13:0] i,
		input logic o);
		ambQ.push_back(g > i ? g - i : 14'h0000);
		@(negedge mclk);
		ambSample = '{done: 1'b1, overrange: o, green: g, ir: i};
		@(negedge mclk);
		ambSample = '{done: 1'b0, overrange: 1'b0, green: ~g, ir: ~i};
	endtask
	task automatic prx(input logic [7:0] v);
		@(negedge mclk);
		proxSample = '{done: 1'b1, value: v};
		@(negedge mclk);
		proxSample = '{done: 1'b0, value: ~v};
	endtask
	// Limits are 0x100 upper and 0x010 lower, so both sides are hit
	task automatic evt();
		logic [31:0] r;
		r = xs();
		if (r[0])
			amb({6'h00, r[15:8]} + 14'h0101, 14'h0000, 1'b0);
		else
			amb({10'h000, r[11:8]}, 14'h0000, 1'b0);
	endtask
	always @(posedge mclk)
		rdPend <= regReq.rd && !reset;
	always @(negedge mclk)
	begin
		cycles++;
		if (rdPend === 1'b1)
			check(regRdData === rdQ.pop_front(), "read data");
		if (ambResultValid === 1'b1)
			check(ambResult === ambQ.pop_front(), "ambient result");
		if (cycles > 20000)
		begin
			check(1'b0, "timeout");
			wrap_up();
		end
	end
	initial
	begin
		int code;
		int need;
		logic [31:0] g;
		logic [31:0] i;
		repeat (4) @(posedge mclk);
		@(negedge mclk);
		reset = 1'b0;
		rd(sensor_irq_pkg::ADDR_STATUS, 8'h04);
		rd(sensor_irq_pkg::ADDR_STATUS, 8'h00);
		rd(sensor_irq_pkg::ADDR_TRIM_GREEN, 8'h7f);
		rd(sensor_irq_pkg::ADDR_TRIM_IR, 8'h7f);
		check(gainTrim === {7'h40, 9'h100}, "trim reset");
		wr(sensor_irq_pkg::ADDR_UP_HI, 8'hc1);
		wr(sensor_irq_pkg::ADDR_LO_LO, 8'h10);
		rd(sensor_irq_pkg::ADDR_UP_HI, 8'h01);
		wr(sensor_irq_pkg::ADDR_UP_HI, 8'h01);
		wr(sensor_irq_pkg::ADDR_CONFIG, 8'h01);
		for (code = 0; code < 4; code++)
		begin
			need = 1 << (code == 3 ? 4 : code);
			wr(sensor_irq_pkg::ADDR_PERSIST, code[7:0]);
			// The last event of the previous run still counts; break it
			amb(14'h0080, 14'h0000, 1'b0);
			repeat (need - 1)
				evt();
			amb(14'h0080, 14'h0000, 1'b0);
			repeat (need - 1)
				evt();
			check(intOe === 1'b0, "early flag");
			evt();
			check(intOe === 1'b1, "flag missing");
			rd(sensor_irq_pkg::ADDR_STATUS, 8'h01);
		end
		wr(sensor_irq_pkg::ADDR_PERSIST, 8'h00);
		amb(14'h0080, 14'h0000, 1'b1);
		check(intOe === 1'b1, "overrange");
		wr(sensor_irq_pkg::ADDR_CONFIG, 8'h00);
		@(negedge mclk);
		check(intOe === 1'b0, "disable clear");
		wr(sensor_irq_pkg::ADDR_CONFIG, 8'h02);
		wr(sensor_irq_pkg::ADDR_PERSIST, 8'h04);
		wr(sensor_irq_pkg::ADDR_PROX_LIMIT, 8'h80);
		for (code = 1; code >= 0; code--)
		begin
			wr(sensor_irq_pkg::ADDR_PROX_DIR, code[0] ? 8'h40 : 8'h00);
			prx(8'h80);
			prx(code[0] ? 8'h90 : 8'h10);
			check(intOe === 1'b0, "prox early");
			prx(code[0] ? 8'h90 : 8'h10);
			check(intOe === 1'b1, "prox flag");
			rd(sensor_irq_pkg::ADDR_STATUS, 8'h02);
		end
		wr(sensor_irq_pkg::ADDR_PERSIST, 8'h00);
		prx(8'h10);
		check(intOe === 1'b1, "prox first");
		rd(sensor_irq_pkg::ADDR_STATUS, 8'h02);
		wr(sensor_irq_pkg::ADDR_CONFIG, 8'h00);
		prx(8'h10);
		prx(8'h10);
		check(intOe === 1'b0, "prox disabled");
		repeat (6)
		begin
			g = xs();
			i = xs();
			amb(g[13:0], i[13:0], 1'b0);
		end
		wr(sensor_irq_pkg::ADDR_TRIM_GREEN, 8'h35);
		wr(sensor_irq_pkg::ADDR_TRIM_IR, 8'ha6);
		rd(sensor_irq_pkg::ADDR_TRIM_GREEN, 8'hca);
		rd(sensor_irq_pkg::ADDR_TRIM_IR, 8'h59);
		check(gainTrim === {7'h1a, 9'h14d}, "host trim");
		wr(sensor_irq_pkg::ADDR_CONFIG, 8'h20);
		repeat (3) @(negedge mclk);
		check(gainTrim === {7'h40, 9'h100}, "factory trim");
		wr(sensor_irq_pkg::ADDR_CONFIG, 8'h00);
		repeat (3) @(negedge mclk);
		check(gainTrim === {7'h1a, 9'h14d}, "trim back");
		wrap_up();
	end
endmodule
bind sensor_threshold_interrupt sensor_irq_properties sensor_irq_properties_inst
	(.mclk(mclk), .reset(reset), .regReq(regReq), .ambSample(ambSample),
	.proxSample(proxSample), .regRdData(regRdData), .intOut(intOut),
	.intOe(intOe), .ambResult(ambResult), .ambResultValid(ambResultValid),
	.gainTrim(gainTrim));
